// ===== verilog/axis_sig_pkg.sv
// package: constants, types and register map of the axis external signal block
// assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus
package axis_sig_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLEAR_TIME_NS = 1000;
  localparam int CLEAR_TIME_CYCLES = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CLEAR_TIME_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // control fields
  localparam int CTRL_POSITIVE_BIT = 0;
  localparam int CTRL_FUNC_LSB = 1;
  localparam logic CTRL_POSITIVE_RESET = 1'b0;
  localparam logic [1:0] CTRL_FUNC_RESET = 2'h0;
  localparam int CLEAR_TIME_WIDTH = 16;
  localparam logic [15:0] CLEAR_TIME_RESET = 16'(CLEAR_TIME_CYCLES);

  // status fields
  localparam int STAT_INPUTS_LSB = 0;
  localparam int STAT_ORIGIN_REQ_BIT = 5;
  localparam int STAT_ORIGIN_DONE_BIT = 6;
  localparam int STAT_CLEAR_BIT = 7;
  localparam int STAT_STOP_INPUT_BIT = 8;
  localparam int STAT_STOP_READY_BIT = 9;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FUNC_START = 2'h0,
    FUNC_SPEED_CHANGE = 2'h1,
    FUNC_SKIP = 2'h2,
    FUNC_NONE = 2'h3
  } ext_func_t;

  typedef enum logic [2:0] {
    METHOD_DOG = 3'h0,
    METHOD_STOPPER1 = 3'h1,
    METHOD_STOPPER2 = 3'h2,
    METHOD_STOPPER3 = 3'h3,
    METHOD_COUNT1 = 3'h4,
    METHOD_COUNT2 = 3'h5
  } method_t;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,
    CLR_WAIT_FEED = 2'b01,
    CLR_PULSE = 2'b11
  } clr_state_t;

  // field inputs, raw pin levels, 1 = energised
  typedef struct packed {
    logic zero;
    logic dog;
    logic ready;
    logic ext_cmd;
    logic stop;
  } ctrl_inputs_t;

  // from the positioning core
  typedef struct packed {
    logic positioning_busy;
    logic switch_control;
    logic origin_return_active;
    logic feed_active;
    method_t method;
    logic clear_request;
    logic origin_return_done;
  } core_status_t;

  // one-cycle events to the positioning core
  typedef struct packed {
    logic stop_positioning;
    logic switch_trigger;
    logic ext_start;
    logic speed_change;
    logic skip;
    logic dog_edge;
    logic zero_edge;
  } core_events_t;

endpackage : axis_sig_pkg

// ===== verilog/input_sync.sv
// two-stage synchroniser bank for asynchronous field inputs
// assumes a single system clock; first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------
  // two flops per input
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : input_sync
`default_nettype wire

// ===== verilog/clear_pulse_timer.sv
// down-counter pulse timer for the deviation counter clear output
// assumes start is a one-cycle pulse from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module clear_pulse_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic [WIDTH-1:0] duration,
  // output
  output logic active_reg
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (start) begin
      count_next = duration;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  // ----------------------------------------
  // counter and output flop
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      active_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      active_reg <= (count_next != '0);
    end
  end

endmodule : clear_pulse_timer
`default_nettype wire

// ===== verilog/axis_external_signal_control.sv
// per-axis interpretation of external control inputs and clear pulse output
// assumes field pins are asynchronous, core signals share sys_clk, wishbone classic slave
//
// Overview of operation
// - stop input turning active halts positioning in progress
// - stop input release never starts motion
// - in switching control the external command edge switches the phase
// - otherwise external command acts as start, speed change or skip by setting
// - origin-return request shown whenever drive unit is not ready
// - ready lost during positioning halts positioning
// - ready returning never restarts positioning
// - ready lost clears origin-return-complete flag
// - clear output during origin return, never in second count method
// - clear output width comes from the duration setting
// - stopper methods issue clear only after feed pulses stop
// - software cannot drive the clear output directly
// - input polarity defaults to negative logic, selectable
// - negative logic: energised is active; positive logic inverts
// - zero marker detected on inactive-to-active edge
// - near-point dog detected on inactive-to-active edge
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module axis_external_signal_control #(
  parameter int CLEAR_WIDTH = axis_sig_pkg::CLEAR_TIME_WIDTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // field pins
  input wire axis_sig_pkg::ctrl_inputs_t field_pins,
  output logic counter_clear_out,
  // positioning core
  input wire axis_sig_pkg::core_status_t core_status,
  output axis_sig_pkg::core_events_t core_events,
  output logic origin_return_request,
  output logic origin_return_complete
);

  axis_sig_pkg::ctrl_inputs_t pins_sync;
  axis_sig_pkg::ctrl_inputs_t act;
  axis_sig_pkg::ctrl_inputs_t act_prev_reg;
  axis_sig_pkg::ctrl_inputs_t rise;
  axis_sig_pkg::ext_func_t func_reg;
  axis_sig_pkg::clr_state_t clr_state_reg;
  axis_sig_pkg::method_t method_reg;
  logic positive_reg;
  logic [CLEAR_WIDTH-1:0] clear_time_reg;
  logic [CLEAR_WIDTH-1:0] pulse_time_reg;
  logic stop_by_input_reg;
  logic stop_by_ready_reg;
  logic clear_start;
  logic ready_fall;
  logic wr_en;
  logic rd_en;
  logic clear_active;

  // ----------------------------------------
  // synchronise and apply polarity
  // ----------------------------------------
  input_sync #(
    .WIDTH($bits(axis_sig_pkg::ctrl_inputs_t))
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(field_pins),
    .sync_out(pins_sync)
  );

  assign act = pins_sync ^ {$bits(axis_sig_pkg::ctrl_inputs_t){positive_reg}};
  assign rise = act & ~act_prev_reg;
  assign ready_fall = act_prev_reg.ready & ~act.ready;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      act_prev_reg <= '0;
    end else begin
      act_prev_reg <= act;
    end
  end

  // ----------------------------------------
  // events to the positioning core
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      core_events <= '0;
    end else begin
      core_events.stop_positioning <= core_status.positioning_busy
                                      & (rise.stop | ready_fall);
      core_events.switch_trigger <= rise.ext_cmd & core_status.switch_control;
      // start only while stop inactive and drive ready; nothing on release
      core_events.ext_start <= rise.ext_cmd & ~core_status.switch_control
                               & (func_reg == axis_sig_pkg::FUNC_START)
                               & ~act.stop & act.ready;
      core_events.speed_change <= rise.ext_cmd & ~core_status.switch_control
                                  & (func_reg == axis_sig_pkg::FUNC_SPEED_CHANGE);
      core_events.skip <= rise.ext_cmd & ~core_status.switch_control
                          & (func_reg == axis_sig_pkg::FUNC_SKIP);
      core_events.dog_edge <= rise.dog;
      core_events.zero_edge <= rise.zero;
    end
  end

  // ----------------------------------------
  // origin-return request and complete
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      origin_return_request <= 1'b1;
      origin_return_complete <= 1'b0;
    end else begin
      origin_return_request <= ~act.ready;
      if (ready_fall || !act.ready) begin
        origin_return_complete <= 1'b0;
      end else if (core_status.origin_return_done) begin
        origin_return_complete <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // clear pulse sequencer
  // ----------------------------------------
  function automatic logic is_stopper(input axis_sig_pkg::method_t m);
    is_stopper = (m == axis_sig_pkg::METHOD_STOPPER1) || (m == axis_sig_pkg::METHOD_STOPPER2)
                 || (m == axis_sig_pkg::METHOD_STOPPER3);
  endfunction : is_stopper

  assign clear_start = ((clr_state_reg == axis_sig_pkg::CLR_IDLE) && core_status.clear_request
                        && core_status.origin_return_active
                        && (core_status.method != axis_sig_pkg::METHOD_COUNT2)
                        && !(is_stopper(core_status.method) && core_status.feed_active))
                       || ((clr_state_reg == axis_sig_pkg::CLR_WAIT_FEED)
                        && !core_status.feed_active);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clr_state_reg <= axis_sig_pkg::CLR_IDLE;
      method_reg <= axis_sig_pkg::METHOD_DOG;
      pulse_time_reg <= '0;
    end else begin
      if (clear_start) begin
        pulse_time_reg <= clear_time_reg;
      end
      unique case (clr_state_reg)
        axis_sig_pkg::CLR_IDLE: begin
          if (core_status.clear_request && core_status.origin_return_active
              && core_status.method != axis_sig_pkg::METHOD_COUNT2) begin
            method_reg <= core_status.method;
            if (is_stopper(core_status.method) && core_status.feed_active) begin
              clr_state_reg <= axis_sig_pkg::CLR_WAIT_FEED;
            end else begin
              clr_state_reg <= axis_sig_pkg::CLR_PULSE;
            end
          end
        end
        axis_sig_pkg::CLR_WAIT_FEED: begin
          if (!core_status.feed_active) begin
            clr_state_reg <= axis_sig_pkg::CLR_PULSE;
          end
        end
        axis_sig_pkg::CLR_PULSE: begin
          if (!clear_active && !clear_start) begin
            clr_state_reg <= axis_sig_pkg::CLR_IDLE;
          end
        end
        default: begin
          clr_state_reg <= axis_sig_pkg::CLR_IDLE;
        end
      endcase
    end
  end

  clear_pulse_timer #(
    .WIDTH(CLEAR_WIDTH)
  ) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(clear_start),
    .duration(clear_time_reg),
    .active_reg(clear_active)
  );

  assign counter_clear_out = clear_active;

  // ----------------------------------------
  // stop cause flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_by_input_reg <= 1'b0;
      stop_by_ready_reg <= 1'b0;
    end else begin
      if (core_status.positioning_busy && rise.stop) begin
        stop_by_input_reg <= 1'b1;
      end else if (wr_en && adr_i == axis_sig_pkg::STATUS_OFFSET && sel_i[1]
                   && dat_i[axis_sig_pkg::STAT_STOP_INPUT_BIT]) begin
        stop_by_input_reg <= 1'b0;
      end
      if (core_status.positioning_busy && ready_fall) begin
        stop_by_ready_reg <= 1'b1;
      end else if (wr_en && adr_i == axis_sig_pkg::STATUS_OFFSET && sel_i[1]
                   && dat_i[axis_sig_pkg::STAT_STOP_READY_BIT]) begin
        stop_by_ready_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // wishbone slave, ack one cycle after request
  // ----------------------------------------
  assign wr_en = cyc_i & stb_i & we_i & ~ack_o;
  assign rd_en = cyc_i & stb_i & ~we_i & ~ack_o;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  // no clear-output bit here: software cannot force it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      positive_reg <= axis_sig_pkg::CTRL_POSITIVE_RESET;
      func_reg <= axis_sig_pkg::ext_func_t'(axis_sig_pkg::CTRL_FUNC_RESET);
      clear_time_reg <= CLEAR_WIDTH'(axis_sig_pkg::CLEAR_TIME_RESET);
    end else if (wr_en) begin
      if (adr_i == axis_sig_pkg::CTRL_OFFSET && sel_i[0]) begin
        positive_reg <= dat_i[axis_sig_pkg::CTRL_POSITIVE_BIT];
        func_reg <= axis_sig_pkg::ext_func_t'(dat_i[axis_sig_pkg::CTRL_FUNC_LSB +: 2]);
      end
      if (adr_i == axis_sig_pkg::CLEAR_TIME_OFFSET) begin
        if (sel_i[0]) begin
          clear_time_reg[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          clear_time_reg[15:8] <= dat_i[15:8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dat_o <= '0;
    end else if (rd_en) begin
      dat_o <= '0;
      unique case (adr_i)
        axis_sig_pkg::CTRL_OFFSET: begin
          dat_o[axis_sig_pkg::CTRL_POSITIVE_BIT] <= positive_reg;
          dat_o[axis_sig_pkg::CTRL_FUNC_LSB +: 2] <= func_reg;
        end
        axis_sig_pkg::CLEAR_TIME_OFFSET: begin
          dat_o[CLEAR_WIDTH-1:0] <= clear_time_reg;
        end
        axis_sig_pkg::STATUS_OFFSET: begin
          dat_o[axis_sig_pkg::STAT_INPUTS_LSB +: 5] <= act;
          dat_o[axis_sig_pkg::STAT_ORIGIN_REQ_BIT] <= origin_return_request;
          dat_o[axis_sig_pkg::STAT_ORIGIN_DONE_BIT] <= origin_return_complete;
          dat_o[axis_sig_pkg::STAT_CLEAR_BIT] <= clear_active;
          dat_o[axis_sig_pkg::STAT_STOP_INPUT_BIT] <= stop_by_input_reg;
          dat_o[axis_sig_pkg::STAT_STOP_READY_BIT] <= stop_by_ready_reg;
        end
        default: begin
          dat_o <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [CLEAR_WIDTH-1:0] high_cnt_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      high_cnt_reg <= '0;
    end else if (clear_active) begin
      high_cnt_reg <= high_cnt_reg + 1'b1;
    end else begin
      high_cnt_reg <= '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_stop_halts_motion: assert property (
    rise.stop && core_status.positioning_busy |=> core_events.stop_positioning)
    else $error("stop input did not halt positioning");
  a_no_start_stopped: assert property (
    core_events.ext_start |-> !$past(act.stop))
    else $error("external start issued while stop active");
  a_switch_trigger: assert property (
    rise.ext_cmd && core_status.switch_control
    |=> core_events.switch_trigger && !core_events.skip && !core_events.ext_start)
    else $error("switch trigger missing in switching control");
  a_func_select: assert property (
    rise.ext_cmd && !core_status.switch_control && func_reg == axis_sig_pkg::FUNC_SKIP
    |=> core_events.skip && !core_events.speed_change)
    else $error("skip request not decoded");
  a_ready_request: assert property (
    !act.ready |=> origin_return_request)
    else $error("origin-return request not raised without ready");
  a_ready_loss_stop: assert property (
    ready_fall && core_status.positioning_busy |=> core_events.stop_positioning)
    else $error("ready loss did not halt positioning");
  a_no_restart: assert property (
    $rose(act.ready) |=> !core_events.ext_start)
    else $error("motion started on ready return");
  a_done_cleared: assert property (
    ready_fall |=> !origin_return_complete)
    else $error("complete flag kept after ready loss");
  a_no_count2_clear: assert property (
    $rose(clear_active) |-> method_reg != axis_sig_pkg::METHOD_COUNT2)
    else $error("clear output in second count method");
  a_clear_width: assert property (
    $fell(clear_active) |-> high_cnt_reg == pulse_time_reg)
    else $error("clear pulse width wrong");
  a_clear_after_feed: assert property (
    $rose(clear_active) && is_stopper(method_reg) |-> !$past(core_status.feed_active))
    else $error("clear pulse while feed pulses active");
  a_dog_edge: assert property (
    $rose(act.dog) |=> core_events.dog_edge ##1 !core_events.dog_edge)
    else $error("dog edge pulse wrong");

  c_clear_pulse: cover property ($fell(clear_active));
  c_stopper_wait: cover property (clr_state_reg == axis_sig_pkg::CLR_WAIT_FEED ##[1:20] clear_active);
  c_stop_event: cover property (core_events.stop_positioning);
  c_skip_event: cover property (core_events.skip);

endmodule : axis_external_signal_control
`default_nettype wire

// ===== testbench/drive_unit_model.sv
// drive unit stand-in: ready output and droop pulse counter
// assumes counter_clear_out from the axis block on the same clock
`timescale 1ns/1ps
`default_nettype none
module drive_unit_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // bench control
  input wire logic fault,
  // axis side
  input wire logic counter_clear_out,
  output logic ready_pin,
  output logic [15:0] droop_reg
);
  // ----------------------------------------
  // ready output, energised while healthy
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ready_pin <= 1'b0;
    end else begin
      ready_pin <= !fault;
    end
  end

  // ----------------------------------------
  // droop count grows while ready_pin is high, cleared by the clear output
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      droop_reg <= 16'h0000;
    end else if (counter_clear_out) begin
      droop_reg <= 16'h0000;
    end else if (ready_pin) begin
      droop_reg <= droop_reg + 16'h0001;
    end
  end
endmodule : drive_unit_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the axis external signal block
// assumes the drive unit model beside it and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [4:0] pins = 5'h00;
  logic fault = 1'b0;
  logic ready_pin;
  logic [15:0] droop_reg;
  logic counter_clear_out;
  axis_sig_pkg::core_status_t cs = '0;
  axis_sig_pkg::core_events_t core_events;
  logic origin_return_request;
  logic origin_return_complete;
  logic [6:0] ev;
  logic [31:0] rdv;
  int ev_cnt[7] = '{default: 0};
  int ev_base[7] = '{default: 0};
  int clr_run = 0;
  int last_len = 0;
  int clr_pulses = 0;
  int last_droop = 0;
  int cycles = 0;
  int error_cnt = 0;
  int samples_checked = 0;
  int p0;

  always #25 sys_clk = ~sys_clk;
  assign ev = core_events;

  axis_external_signal_control u_axis_external_signal_control (
    .sys_clk(sys_clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .field_pins({pins[4:3], ready_pin, pins[1:0]}), .counter_clear_out(counter_clear_out),
    .core_status(cs), .core_events(core_events),
    .origin_return_request(origin_return_request),
    .origin_return_complete(origin_return_complete));

  drive_unit_model u_drive_unit_model (
    .sys_clk(sys_clk), .rstn(rstn), .fault(fault),
    .counter_clear_out(counter_clear_out), .ready_pin(ready_pin), .droop_reg(droop_reg));

  // ----------------------------------------
  // monitors and timeout
  // ----------------------------------------
  always @(posedge sys_clk) begin
    for (int i = 0; i < 7; i++) ev_cnt[i] += (ev[i] === 1'b1);
    if (counter_clear_out === 1'b1) begin
      clr_run++;
    end else if (clr_run != 0) begin
      last_len = clr_run;
      last_droop = droop_reg;
      clr_pulses++;
      clr_run = 0;
    end
    if (++cycles > 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    @(posedge sys_clk);
    while (ack_o !== 1'b1) @(posedge sys_clk);
    rdv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  task automatic ev_expect(input logic [6:0] exp);
    for (int i = 0; i < 7; i++) check(32'(ev_cnt[i] - ev_base[i]), {31'h0, exp[i]});
    ev_base = ev_cnt;
  endtask : ev_expect

  task automatic pin_pulse(input int b, input logic [6:0] exp);
    ev_base = ev_cnt;
    pins[b] <= 1'b1;
    wt(4);
    pins[b] <= 1'b0;
    wt(6);
    ev_expect(exp);
  endtask : pin_pulse

  task automatic clear_req();
    cs.clear_request <= 1'b1;
    wt(1);
    cs.clear_request <= 1'b0;
  endtask : clear_req

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    wt(3);
    check({31'h0, origin_return_request}, 32'h1);
    wt(3);
    rstn <= 1'b1;
    wt(1);
    wb(1'b0, axis_sig_pkg::CTRL_OFFSET, 32'h0);
    check(rdv, 32'h0);
    wb(1'b0, axis_sig_pkg::CLEAR_TIME_OFFSET, 32'h0);
    check(rdv, 32'(axis_sig_pkg::CLEAR_TIME_CYCLES));
    wb(1'b0, 8'h3C, 32'h0);
    check(rdv, 32'h0);
    wt(6);
    check({31'h0, origin_return_request}, 32'h0);
    cs.origin_return_done <= 1'b1;
    wt(1);
    cs.origin_return_done <= 1'b0;
    wt(2);
    check({31'h0, origin_return_complete}, 32'h1);
    ev_base = ev_cnt;
    cs.positioning_busy <= 1'b1;
    fault <= 1'b1;
    wt(8);
    ev_expect(7'h40);
    check({30'h0, origin_return_request, origin_return_complete}, 32'h2);
    fault <= 1'b0;
    wt(8);
    ev_expect(7'h00);
    check({30'h0, origin_return_request, origin_return_complete}, 32'h0);
    wb(1'b0, axis_sig_pkg::STATUS_OFFSET, 32'h0);
    check({31'h0, rdv[axis_sig_pkg::STAT_STOP_READY_BIT]}, 32'h1);
    wb(1'b1, axis_sig_pkg::STATUS_OFFSET, 32'h200);
    wb(1'b0, axis_sig_pkg::STATUS_OFFSET, 32'h0);
    check({31'h0, rdv[axis_sig_pkg::STAT_STOP_READY_BIT]}, 32'h0);
    pins[0] <= 1'b1;
    wt(2);
    ev_expect(7'h00);
    wt(6);
    ev_expect(7'h40);
    pins[0] <= 1'b0;
    wt(8);
    ev_expect(7'h00);
    wb(1'b0, axis_sig_pkg::STATUS_OFFSET, 32'h0);
    check({31'h0, rdv[axis_sig_pkg::STAT_STOP_INPUT_BIT]}, 32'h1);
    cs.positioning_busy <= 1'b0;
    cs.switch_control <= 1'b1;
    pin_pulse(1, 7'h20);
    cs.switch_control <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, axis_sig_pkg::CTRL_OFFSET, 32'(f << 1));
      pin_pulse(1, (f == 3) ? 7'h00 : 7'(7'h10 >> f));
    end
    pin_pulse(3, 7'h02);
    pin_pulse(4, 7'h01);
    wb(1'b0, axis_sig_pkg::STATUS_OFFSET, 32'h0);
    check({27'h0, rdv[4:0]}, 32'h04);
    wb(1'b1, axis_sig_pkg::CTRL_OFFSET, 32'h1);
    wt(5);
    wb(1'b0, axis_sig_pkg::STATUS_OFFSET, 32'h0);
    check({27'h0, rdv[4:0]}, 32'h1B);
    check({31'h0, origin_return_request}, 32'h1);
    wb(1'b1, axis_sig_pkg::CTRL_OFFSET, 32'h0);
    wb(1'b1, axis_sig_pkg::CLEAR_TIME_OFFSET, 32'h7);
    wt(6);
    cs.origin_return_active <= 1'b1;
    for (int m = 0; m < 6; m++) begin
      p0 = clr_pulses;
      cs.method <= axis_sig_pkg::method_t'(m);
      wt(1);
      clear_req();
      wt(15);
      check(32'(clr_pulses - p0), (m == 5) ? 32'h0 : 32'h1);
      check(32'(last_len), 32'h7);
      check(32'(last_droop), 32'h0);
    end
    p0 = clr_pulses;
    cs.method <= axis_sig_pkg::METHOD_STOPPER2;
    cs.feed_active <= 1'b1;
    wt(1);
    clear_req();
    wt(6);
    check({31'h0, counter_clear_out}, 32'h0);
    cs.feed_active <= 1'b0;
    wt(15);
    check(32'(clr_pulses - p0), 32'h1);
    cs.origin_return_active <= 1'b0;
    p0 = clr_pulses;
    wb(1'b1, axis_sig_pkg::STATUS_OFFSET, 32'hFFFFFFFF);
    wt(4);
    check(32'(clr_pulses - p0), 32'h0);
    check({31'h0, counter_clear_out}, 32'h0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
